//--- verilog/afsl_pkg.sv
// Constants, field layouts and carrier types for the axis fault status logic.
// Assumes a single 25 MHz clock domain and one coarse update strobe.
package afsl_pkg;

    localparam int POS_W          = 32;
    localparam int FAULT_W        = 32;
    localparam int MOD_FAULT_W    = 8;

    // Axis fault word positions.
    localparam int AX_POS_SOFT    = 0;
    localparam int AX_NEG_SOFT    = 1;
    localparam int AX_POS_HARD    = 2;
    localparam int AX_NEG_HARD    = 3;
    localparam int AX_FB_LOSS     = 4;
    localparam int AX_FB_NOISE    = 5;
    localparam int AX_POS_ERR     = 8;
    localparam int AX_DRIVE       = 9;

    // Module fault word positions.
    localparam int MF_HOST_SYNC   = 0;
    localparam int MF_MOD_SYNC    = 1;
    localparam int MF_TIMEBASE    = 2;
    localparam int MF_HW          = 3;

    localparam logic [FAULT_W-1:0]     AXIS_FAULT_RST = 32'h0000_0000;
    localparam logic [MOD_FAULT_W-1:0] MOD_FAULT_RST  = 8'h00;

    localparam int MISS_LIMIT     = 4;
    localparam int MISS_W         = 3;

    typedef struct packed {
        logic a_p;
        logic a_n;
        logic b_p;
        logic b_n;
        logic z_p;
        logic z_n;
        logic pwr_ok;
    } afsl_fb_type;

    // Healthy pin pattern: every pair opposite and encoder power present.
    localparam afsl_fb_type FB_IDLE = 7'h55;

    typedef struct packed {
        logic [FAULT_W-1:0]     axis_fault_word;
        logic [MOD_FAULT_W-1:0] module_fault_word;
    } afsl_report_type;

endpackage

//--- verilog/afsl_fb_mon.sv
// Differential feedback monitor for one feedback source.
// Assumes the pins have already passed a two-stage synchroniser.
`timescale 1ns/100ps
module afsl_fb_mon (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire afsl_pkg::afsl_fb_type fb,
    output logic                      loss_now,
    output logic                      noise_now
);
    import afsl_pkg::*;

    logic a_prev_r;
    logic b_prev_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Match the synchroniser's reset pattern so no edge is invented.
            a_prev_r <= FB_IDLE.a_p;
            b_prev_r <= FB_IDLE.b_p;
        end else begin
            a_prev_r <= fb.a_p;
            b_prev_r <= fb.b_p;
        end
    end

    always_comb begin
        loss_now = (fb.a_p == fb.a_n) || (fb.b_p == fb.b_n) ||
                   (fb.z_p == fb.z_n) || !fb.pwr_ok;
        // Edges on both channels in one sample cannot be quadrature.
        noise_now = (fb.a_p != a_prev_r) && (fb.b_p != b_prev_r);
    end
endmodule

//--- verilog/afsl_top.sv
// Fault detection and status reporting for one servo axis.
// Assumes update_strobe marks each coarse update period in clk domain.
`timescale 1ns/100ps
module afsl_top #(
    parameter int NUM_AXES = 1
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          update_strobe,
    input  wire logic                          host_update_seen,
    input  wire logic                          host_side_sync_loss_flag,
    input  wire logic                          timebase_sync_error_flag,
    input  wire logic                          module_hw_error_flag,
    input  wire logic                          axis_fault_clear_cmd,
    input  wire logic                          axis_shutdown_clear_cmd,
    input  wire logic signed [afsl_pkg::POS_W-1:0] actual_pos,
    input  wire logic signed [afsl_pkg::POS_W-1:0] command_pos,
    input  wire logic signed [afsl_pkg::POS_W-1:0] max_pos_travel,
    input  wire logic signed [afsl_pkg::POS_W-1:0] max_neg_travel,
    input  wire logic        [afsl_pkg::POS_W-1:0] pos_err_tolerance,
    input  wire logic                          pos_limit_switch,
    input  wire logic                          neg_limit_switch,
    input  wire logic                          drive_fault_in,
    input  wire afsl_pkg::afsl_fb_type         fb_pins,
    output afsl_pkg::afsl_report_type          report_r [NUM_AXES],
    output logic                               report_valid_r,
    output logic                               module_shutdown_r
);
    import afsl_pkg::*;

    afsl_fb_type             fb_s1_r;
    afsl_fb_type             fb_s2_r;
    logic [2:0]              sw_s1_r;
    logic [2:0]              sw_s2_r;
    logic                    loss_now;
    logic                    noise_now;
    logic                    clear_cmd;
    logic signed [POS_W:0]   pos_err;
    logic        [POS_W:0]   pos_err_mag;
    logic                    pos_soft_limit_flag;
    logic                    neg_soft_limit_flag;
    logic                    pos_limit_switch_flag_r;
    logic                    neg_limit_switch_flag_r;
    logic                    fb_loss_r;
    logic                    fb_noise_r;
    logic                    pos_err_flag_r;
    logic                    external_drive_error_flag_r;
    logic [MISS_W-1:0]       miss_cnt_r;
    logic                    mod_sync_r;
    logic                    seen_r;
    logic [FAULT_W-1:0]      axis_fault_word;
    logic [MOD_FAULT_W-1:0]  module_fault_word;

    // Pins cross into the clock domain before any logic looks at them.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // An all-zero reset would look like a broken encoder on release.
            fb_s1_r <= FB_IDLE;
            fb_s2_r <= FB_IDLE;
            sw_s1_r <= 3'h0;
            sw_s2_r <= 3'h0;
        end else begin
            fb_s1_r <= fb_pins;
            fb_s2_r <= fb_s1_r;
            sw_s1_r <= {drive_fault_in, neg_limit_switch, pos_limit_switch};
            sw_s2_r <= sw_s1_r;
        end
    end

    afsl_fb_mon u_fb_mon (
        .clk       (clk),
        .rst_n     (rst_n),
        .fb        (fb_s2_r),
        .loss_now  (loss_now),
        .noise_now (noise_now)
    );

    assign clear_cmd = axis_fault_clear_cmd || axis_shutdown_clear_cmd;

    // Either actual or commanded position past a limit counts.
    assign pos_soft_limit_flag = (actual_pos > max_pos_travel) ||
                                 (command_pos > max_pos_travel);
    assign neg_soft_limit_flag = (actual_pos < max_neg_travel) ||
                                 (command_pos < max_neg_travel);

    // One extra bit keeps the subtraction from wrapping.
    assign pos_err = {command_pos[POS_W-1], command_pos} -
                     {actual_pos[POS_W-1], actual_pos};
    assign pos_err_mag = pos_err[POS_W] ? (POS_W+1)'(-pos_err)
                                        : (POS_W+1)'(pos_err);

    // Set wins over clear so a persisting cause reasserts at once.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_limit_switch_flag_r     <= 1'b0;
            neg_limit_switch_flag_r     <= 1'b0;
            fb_loss_r                   <= 1'b0;
            fb_noise_r                  <= 1'b0;
            pos_err_flag_r              <= 1'b0;
            external_drive_error_flag_r <= 1'b0;
        end else begin
            pos_limit_switch_flag_r <= sw_s2_r[0] ||
                (pos_limit_switch_flag_r && !clear_cmd);
            neg_limit_switch_flag_r <= sw_s2_r[1] ||
                (neg_limit_switch_flag_r && !clear_cmd);
            fb_loss_r <= loss_now ||
                (fb_loss_r && !clear_cmd);
            fb_noise_r <= noise_now ||
                (fb_noise_r && !clear_cmd);
            pos_err_flag_r <= (pos_err_mag > {1'b0, pos_err_tolerance}) ||
                (pos_err_flag_r && !clear_cmd);
            external_drive_error_flag_r <= sw_s2_r[2] ||
                (external_drive_error_flag_r && !clear_cmd);
        end
    end

    // Counts update periods without a controller update; a fifth miss
    // in a row faults and shuts down, a fresh update clears both.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_r     <= 1'b0;
            miss_cnt_r <= 3'h0;
            mod_sync_r <= 1'b0;
        end else begin
            // An update in the strobe cycle belongs to the period that ends.
            if (update_strobe) begin
                seen_r <= 1'b0;
            end else if (host_update_seen) begin
                seen_r <= 1'b1;
            end
            if (update_strobe) begin
                if (seen_r || host_update_seen) begin
                    miss_cnt_r <= 3'h0;
                    mod_sync_r <= 1'b0;
                end else if (miss_cnt_r >= MISS_W'(MISS_LIMIT)) begin
                    mod_sync_r <= 1'b1;
                end else begin
                    miss_cnt_r <= miss_cnt_r + 3'h1;
                end
            end
        end
    end

    always_comb begin
        axis_fault_word = AXIS_FAULT_RST;
        axis_fault_word[AX_POS_SOFT] = pos_soft_limit_flag;
        axis_fault_word[AX_NEG_SOFT] = neg_soft_limit_flag;
        axis_fault_word[AX_POS_HARD] = pos_limit_switch_flag_r;
        axis_fault_word[AX_NEG_HARD] = neg_limit_switch_flag_r;
        axis_fault_word[AX_FB_LOSS]  = fb_loss_r;
        axis_fault_word[AX_FB_NOISE] = fb_noise_r;
        axis_fault_word[AX_POS_ERR]  = pos_err_flag_r;
        axis_fault_word[AX_DRIVE]    = external_drive_error_flag_r;
        module_fault_word = MOD_FAULT_RST;
        // The host flag is the controller's own verdict, mirrored back.
        module_fault_word[MF_HOST_SYNC] = host_side_sync_loss_flag;
        module_fault_word[MF_MOD_SYNC]  = mod_sync_r;
        module_fault_word[MF_TIMEBASE]  = timebase_sync_error_flag;
        module_fault_word[MF_HW]        = module_hw_error_flag;
    end

    // Reports refresh only on the update strobe and hold in between.
    genvar g;
    generate
        for (g = 0; g < NUM_AXES; g++) begin : g_axis
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    report_r[g] <= '0;
                end else if (update_strobe) begin
                    report_r[g].axis_fault_word   <= axis_fault_word;
                    report_r[g].module_fault_word <= module_fault_word;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            report_valid_r    <= 1'b0;
            module_shutdown_r <= 1'b0;
        end else begin
            report_valid_r    <= update_strobe;
            module_shutdown_r <= mod_sync_r || host_side_sync_loss_flag;
        end
    end
endmodule

//--- testbench/afsl_host_model.sv
// Behavioural host controller on the far side of the synchronous link.
// Assumes strobe comes from the bench and report valid from the module under test.
`timescale 1ns/100ps
module afsl_host_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic update_strobe,
    input  wire logic report_valid_r,
    input  wire logic skip,
    input  wire logic drop,
    output logic      host_update_seen,
    output logic      host_side_sync_loss_flag
);
    logic stb_d_r;
    int   lost_r;
    // Skip and drop model a broken link; the bench commands both.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stb_d_r <= 1'b0;
            host_update_seen <= 1'b0;
            lost_r <= 0;
            host_side_sync_loss_flag <= 1'b0;
        end else begin
            stb_d_r <= update_strobe;
            host_update_seen <= stb_d_r & ~skip;
            if (report_valid_r) begin
                lost_r <= drop ? lost_r + 1 : 0;
                host_side_sync_loss_flag <= drop && lost_r >= 4;
            end
        end
    end
endmodule

//--- testbench/afsl_top_asserts.sv
// Port checks for the axis fault status logic.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/100ps
module afsl_top_asserts #(
    parameter int NUM_AXES = 1
) (
    input wire logic                          clk,
    input wire logic                          rst_n,
    input wire logic                          update_strobe,
    input wire logic                          host_side_sync_loss_flag,
    input wire logic signed [afsl_pkg::POS_W-1:0] actual_pos,
    input wire logic signed [afsl_pkg::POS_W-1:0] command_pos,
    input wire logic signed [afsl_pkg::POS_W-1:0] max_pos_travel,
    input wire logic signed [afsl_pkg::POS_W-1:0] max_neg_travel,
    input wire logic        [afsl_pkg::POS_W-1:0] pos_err_tolerance,
    input wire logic                          drive_fault_in,
    input wire afsl_pkg::afsl_report_type     report_r [NUM_AXES],
    input wire logic                          report_valid_r
);
    import afsl_pkg::*;
    // One extra bit keeps the error magnitude free of overflow.
    wire signed [32:0] pdiff = command_pos - actual_pos;
    wire [32:0] pmag = pdiff[32] ? -pdiff : pdiff;
    wire perr_now = pmag > {1'b0, pos_err_tolerance};
    wire [1:0] soft_now = {actual_pos < max_neg_travel ||
        command_pos < max_neg_travel, actual_pos > max_pos_travel ||
        command_pos > max_pos_travel};
    wire [FAULT_W-1:0] ax = report_r[0].axis_fault_word;
    wire [MOD_FAULT_W-1:0] mf = report_r[0].module_fault_word;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    AST_VALID: assert property (update_strobe |=> report_valid_r)
        else $error("report valid missing after strobe");
    AST_HOLD: assert property (!report_valid_r |-> $stable(report_r[0]))
        else $error("report changed without a strobe");
    AST_RSVD: assert property (report_valid_r |-> mf[7:4] == 4'h0)
        else $error("reserved module bits set");
    AST_HOST: assert property (update_strobe |=>
        mf[MF_HOST_SYNC] == $past(host_side_sync_loss_flag))
        else $error("host sync bit not mirrored");
    AST_MIRROR: assert property (report_valid_r |->
        report_r[0] == report_r[NUM_AXES-1])
        else $error("axes disagree");
    AST_SOFT: assert property (update_strobe |=> ax[1:0] == $past(soft_now))
        else $error("soft limit bits wrong");
    AST_DRIVE: assert property (drive_fault_in [*5] ##0 update_strobe |=>
        ax[AX_DRIVE])
        else $error("drive fault not reported");
    AST_PERR: assert property (perr_now [*3] ##0 update_strobe |=>
        ax[AX_POS_ERR])
        else $error("position error not reported");
    COV_DRIVE: cover property (update_strobe ##1 ax[AX_DRIVE]);
    COV_SOFT: cover property (update_strobe ##1 ax[AX_NEG_SOFT]);
    COV_MSYNC: cover property (report_valid_r && mf[MF_MOD_SYNC]);
endmodule
bind afsl_top afsl_top_asserts #(
    .NUM_AXES(NUM_AXES)
) chk (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .update_strobe            (update_strobe),
    .host_side_sync_loss_flag (host_side_sync_loss_flag),
    .actual_pos               (actual_pos),
    .command_pos              (command_pos),
    .max_pos_travel           (max_pos_travel),
    .max_neg_travel           (max_neg_travel),
    .pos_err_tolerance        (pos_err_tolerance),
    .drive_fault_in           (drive_fault_in),
    .report_r                 (report_r),
    .report_valid_r           (report_valid_r)
);

//--- testbench/afsl_top_tb.sv
// Self-checking bench for afsl_top against an integer reference model.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/100ps
module afsl_top_tb;
    import afsl_pkg::*;
    localparam int NUM_AXES = 2;
    logic clk = 1'b0, rst_n = 1'b0, update_strobe = 1'b0;
    logic host_update_seen, host_side_sync_loss_flag;
    logic timebase_sync_error_flag = 1'b0, module_hw_error_flag = 1'b0;
    logic axis_fault_clear_cmd = 1'b0, axis_shutdown_clear_cmd = 1'b0;
    logic signed [POS_W-1:0] actual_pos = '0, command_pos = '0;
    logic signed [POS_W-1:0] max_pos_travel = 32'sh64;
    logic signed [POS_W-1:0] max_neg_travel = -32'sh64;
    logic [POS_W-1:0] pos_err_tolerance = 32'h32;
    logic pos_limit_switch = 1'b0, neg_limit_switch = 1'b0;
    logic drive_fault_in = 1'b0, skip = 1'b0, drop = 1'b0;
    afsl_fb_type fb_pins = 7'h55;
    afsl_report_type report_r [NUM_AXES];
    logic report_valid_r, module_shutdown_r;
    int n_errors = 0, compares = 0, hc = 0, mc = 0;
    logic [5:0] lat = 6'h0;
    logic pa = 1'b1, pb = 1'b1, msync = 1'b0;
    always #20 clk = ~clk;
    afsl_top #(
        .NUM_AXES(NUM_AXES)
    ) uut (
        .clk                      (clk),
        .rst_n                    (rst_n),
        .update_strobe            (update_strobe),
        .host_update_seen         (host_update_seen),
        .host_side_sync_loss_flag (host_side_sync_loss_flag),
        .timebase_sync_error_flag (timebase_sync_error_flag),
        .module_hw_error_flag     (module_hw_error_flag),
        .axis_fault_clear_cmd     (axis_fault_clear_cmd),
        .axis_shutdown_clear_cmd  (axis_shutdown_clear_cmd),
        .actual_pos               (actual_pos),
        .command_pos              (command_pos),
        .max_pos_travel           (max_pos_travel),
        .max_neg_travel           (max_neg_travel),
        .pos_err_tolerance        (pos_err_tolerance),
        .pos_limit_switch         (pos_limit_switch),
        .neg_limit_switch         (neg_limit_switch),
        .drive_fault_in           (drive_fault_in),
        .fb_pins                  (fb_pins),
        .report_r                 (report_r),
        .report_valid_r           (report_valid_r),
        .module_shutdown_r        (module_shutdown_r)
    );
    afsl_host_model host (
        .clk                      (clk),
        .rst_n                    (rst_n),
        .update_strobe            (update_strobe),
        .report_valid_r           (report_valid_r),
        .skip                     (skip),
        .drop                     (drop),
        .host_update_seen         (host_update_seen),
        .host_side_sync_loss_flag (host_side_sync_loss_flag)
    );
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One coarse period of seven cycles; inputs settle before the strobe.
    task automatic period(input bit sk, input bit dr);
        int a, c;
        logic na, nb, zb, pw, ps, ng, pe, cl;
        logic [5:0] cause;
        logic [39:0] exp;
        skip = sk;
        drop = dr;
        hc = dr ? hc + 1 : 0;
        a = $urandom_range(300) - 150;
        c = $urandom_range(300) - 150;
        actual_pos = a;
        command_pos = c;
        pos_limit_switch = $urandom_range(3) == 0;
        neg_limit_switch = $urandom_range(3) == 0;
        drive_fault_in = $urandom_range(3) == 0;
        timebase_sync_error_flag = $urandom_range(1);
        module_hw_error_flag = $urandom_range(1);
        na = $urandom_range(1);
        nb = $urandom_range(1);
        zb = $urandom_range(7) == 0;
        pw = $urandom_range(7) != 0;
        fb_pins = {na, ~na, nb, ~nb, ~zb, 1'b0, pw};
        ps = a > 100 || c > 100;
        ng = a < -100 || c < -100;
        pe = a - c > 50 || c - a > 50;
        cause = {pos_limit_switch, neg_limit_switch, zb | ~pw,
                 na != pa && nb != pb, pe, drive_fault_in};
        lat = lat | cause;
        pa = na;
        pb = nb;
        cl = $urandom_range(3) == 0;
        repeat (4) @(posedge clk);
        #1 axis_fault_clear_cmd = cl & $urandom_range(1);
        axis_shutdown_clear_cmd = cl & ~axis_fault_clear_cmd;
        if (cl)
            lat = cause & 6'h3B;
        @(posedge clk);
        #1 axis_fault_clear_cmd = 1'b0;
        axis_shutdown_clear_cmd = 1'b0;
        @(posedge clk);
        #1 check(module_shutdown_r, msync | (hc > 4));
        update_strobe = 1'b1;
        exp = {22'h0, lat[0], lat[1], 2'b0, lat[2], lat[3], lat[4], lat[5],
               ng, ps, 4'h0, module_hw_error_flag, timebase_sync_error_flag,
               msync, hc > 4};
        mc = sk ? mc + 1 : 0;
        msync = mc > 4;
        @(posedge clk);
        #1 update_strobe = 1'b0;
        check(report_valid_r, 40'h1);
        for (int k = 0; k < NUM_AXES; k++)
            check(report_r[k], exp);
    endtask
    initial begin
        void'($urandom(32'h493A));
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        period(1'b1, 1'b0);
        repeat (60) period($urandom_range(5) == 0, 1'b0);
        repeat (7) period(1'b1, 1'b1);
        repeat (3) period(1'b0, 1'b0);
        final_report();
    end
    initial begin
        #100000;
        n_errors++;
        final_report();
    end
endmodule
